// [cra_regs.svh]
// Constants of the read-direction word assembler: codes, widths and counts.
// Assumes inclusion by the package and by the design file; definitions only.
//
// Contract
// - Four phases 00,10,11,01, one phase_o bit changes per step.
// - Phase 00 takes start marks, waits data.
// - Full word decrements count (tape block mode: end mark does); store increments address. Input word mode without sign: busy at position two, no decrement.
// - First char, sign on: illegal sign flags error.
// - Sign off, first char: position preset one.
// - Phase 10 stalls at position zero while busy bit pending.
// - Later characters skip phase 10 checks.
// - Phase 11: shift three, count, shift three.
// - Position increments unless zero at end mark.
// - Tape busy and decrement table at 7/0.
// - Input device busy and decrement table.
// - Parity error on character sets parity flag.
// - Stop code pads zero characters to seven.
// - Phase 01 raises completion when order done.
// - Phase 01 loads non-end character low.
// - Zero position end mark sets block flag.
// - Position seven wraps to zero, back 00.
// - Bad mark sets timing error and halt.
// - End mark decodes as 10001001.
// - Start mark decodes as 10100100.
// - Fifteen-bit address counter supplies store address.
// - Thirty-seven-bit buffer filled by three-bit shifts.
// - Halt flag freezes the sequencer; character buffer and store port still run.
`ifndef CRA_REGS_SVH
`define CRA_REGS_SVH

// -----------------------------------------------------------------------------
// Character codes and field sizes
// -----------------------------------------------------------------------------
`define CRA_END_MARK     8'h89
`define CRA_START_MARK   8'hA4
`define CRA_SIGN_PLUS    8'h01
`define CRA_SIGN_MINUS   8'h02
`define CRA_CHAR_W       8
`define CRA_ADDR_W       15
`define CRA_BUF_W        37
`define CRA_POS_W        3
`define CRA_SHIFT        3
`define CRA_SLICE_W      6
`define CRA_POS_LAST     3'h7
`define CRA_POS_ZERO     3'h0
`define CRA_POS_ONE      3'h1
`define CRA_POS_TWO      3'h2
`define CRA_FIFO_DEPTH   16
`define CRA_WBC_W        12

`endif

// [cra_pkg.sv]
// Types shared by the word assembler, the character source and the bench.
// Assumes cra_regs.svh is on the include path.
`include "cra_regs.svh"

package cra_pkg;

  // One character as it arrives from the device.
  typedef struct packed {
    logic                  stop;
    logic                  par_err;
    logic [`CRA_CHAR_W-1:0] data;
  } cra_char_t;

  // Phase encoding, one-hot.
  typedef enum logic [3:0] {
    CRA_PH_00 = 4'h1,
    CRA_PH_10 = 4'h2,
    CRA_PH_11 = 4'h4,
    CRA_PH_01 = 4'h8
  } cra_phase_t;

  // Error and mark flags shown to software.
  typedef struct packed {
    logic sign_error_flag;
    logic parity_error_flag;
    logic timing_read_error;
    logic converter_halt_flag;
    logic block_mark_flag;
  } cra_flags_t;

endpackage

// [cra_read_asm.sv]
// Read-direction converter: character buffer and word assembler.
// Assumes one 20 MHz clock, device characters already in this clock domain
// with a valid/ready handshake, and a memory port that acknowledges a store.
`timescale 1ns/1ns
`include "cra_regs.svh"

// -----------------------------------------------------------------------------
// Character buffer
// -----------------------------------------------------------------------------
module cra_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = `CRA_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             flush_i,
  // Fill side.
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Depth must be a power of two so the pointers wrap by themselves.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("cra_fifo depth must be a power of two of at least two");
  end

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage; a write never lands on the entry being read while full.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || flush_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// -----------------------------------------------------------------------------
// Word assembler
// -----------------------------------------------------------------------------
module cra_read_asm #(
  parameter int WBC_W = `CRA_WBC_W,
  parameter int DEPTH = `CRA_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  // Order control.
  input  wire logic                     clear_i,
  input  wire logic                     start_i,
  input  wire logic                     word_or_block_select_i,
  input  wire logic                     sign_interp_flag_i,
  input  wire logic                     tape_device_level_i,
  input  wire logic [WBC_W-1:0]         count_i,
  input  wire logic [`CRA_ADDR_W-1:0]   addr_i,
  // Character stream from the device.
  input  wire logic                     char_valid_i,
  output logic                          char_ready_o,
  input  wire cra_pkg::cra_char_t       char_i,
  // Memory store port.
  output logic                          mem_request_bit_o,
  input  wire logic                     mem_ack_i,
  output logic [`CRA_ADDR_W-1:0]        mem_addr_o,
  output logic [`CRA_BUF_W-1:0]         mem_data_o,
  // Status.
  output logic                          end_level_o,
  output cra_pkg::cra_flags_t           flags_o,
  output logic [1:0]                    phase_o,
  output logic [`CRA_POS_W-1:0]         char_pos_o,
  output logic [WBC_W-1:0]              word_block_counter_o
);
  import cra_pkg::*;

  if (WBC_W < 1 || WBC_W > 32) begin : g_bad_wbc
    $error("cra_read_asm counter width out of range");
  end

  cra_phase_t            ph_q;
  logic [1:0]            sub_q;
  logic [`CRA_CHAR_W-1:0] char_input_reg_q;
  logic [`CRA_BUF_W-1:0] word_assembly_buffer_q;
  logic [`CRA_POS_W-1:0] pos_q;
  logic [`CRA_POS_W-1:0] pos_d;
  logic [WBC_W-1:0]      wbc_q;
  logic [`CRA_ADDR_W-1:0] adc_q;
  logic                  bb_q;
  logic                  active_q;
  logic                  end_q;
  logic                  pad_q;
  logic                  par_q;
  cra_flags_t            fl_q;
  cra_char_t             st_data;
  logic                  st_valid;
  logic                  st_pop;
  logic                  end_mark;
  logic                  start_mark;
  logic                  legal_sign;
  logic                  run;
  logic                  set_bb;
  logic                  dec_wbc;
  logic                  wbc_zero;

  // ---------------------------------------------------------------------------
  // Staging buffer between device and character register
  // ---------------------------------------------------------------------------
  // Back-pressure reaches the device: characters wait here while the
  // phase sequencer is stalled on a pending store.
  cra_fifo #(
    .WIDTH ($bits(cra_char_t)),
    .DEPTH (DEPTH)
  ) u_stage (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (clear_i),
    .in_valid_i  (char_valid_i),
    .in_ready_o  (char_ready_o),
    .in_data_i   (char_i),
    .out_valid_o (st_valid),
    .out_ready_i (st_pop),
    .out_data_o  (st_data)
  );

  // ---------------------------------------------------------------------------
  // Decodes
  // ---------------------------------------------------------------------------
  assign end_mark   = (char_input_reg_q == `CRA_END_MARK);
  assign start_mark = (char_input_reg_q == `CRA_START_MARK);
  assign legal_sign = (char_input_reg_q == `CRA_SIGN_PLUS) ||
                      (char_input_reg_q == `CRA_SIGN_MINUS);
  assign wbc_zero   = (wbc_q == '0);
  // Halt freezes the sequencer until a clear.
  assign run        = active_q && !fl_q.converter_halt_flag;
  // A character is only drawn in phase 00 and never while padding.
  assign st_pop     = run && (ph_q == CRA_PH_00) && !pad_q && st_valid;

  // Position update in the middle step of phase 11.
  always_comb begin
    pos_d = pos_q;
    if (!(pos_q == `CRA_POS_ZERO && end_mark)) begin
      pos_d = pos_q + `CRA_POS_ONE;
    end
  end

  // Busy and decrement table, evaluated on the updated position.
  always_comb begin
    set_bb  = 1'b0;
    dec_wbc = 1'b0;
    if (tape_device_level_i) begin
      if (!end_mark && pos_d == `CRA_POS_LAST) begin
        set_bb  = 1'b1;
        dec_wbc = !word_or_block_select_i;
      end else if (word_or_block_select_i && pos_d == `CRA_POS_ZERO && end_mark) begin
        dec_wbc = 1'b1;
      end
    end else if (sign_interp_flag_i) begin
      if (pos_d == `CRA_POS_LAST) begin
        set_bb  = 1'b1;
        dec_wbc = 1'b1;
      end
    end else if (!word_or_block_select_i) begin
      set_bb = (pos_d == `CRA_POS_TWO);
    end else if (pos_d == `CRA_POS_LAST) begin
      set_bb  = 1'b1;
      dec_wbc = !wbc_zero;
    end
  end

  // ---------------------------------------------------------------------------
  // Order activity and completion
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || clear_i) begin
      active_q <= 1'b0;
      end_q    <= 1'b0;
    end else if (start_i) begin
      active_q <= 1'b1;
      end_q    <= 1'b0;
    end else if (run && ph_q == CRA_PH_01 && wbc_zero) begin
      // Completion is judged on the count, which follows word or block mode.
      end_q    <= 1'b1;
      active_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Phase sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || clear_i || start_i) begin
      ph_q  <= CRA_PH_00;
      sub_q <= 2'h0;
    end else if (run) begin
      case (ph_q)
        CRA_PH_00: begin
          // Advance with a drawn character and no block mark pending, or while padding.
          if ((st_pop && !fl_q.block_mark_flag) || pad_q) begin
            ph_q <= CRA_PH_10;
          end
        end
        CRA_PH_10: begin
          if (!bb_q || pos_q != `CRA_POS_ZERO) begin
            ph_q <= CRA_PH_11;
          end
        end
        CRA_PH_11: begin
          sub_q <= sub_q + 2'h1;
          if (sub_q == 2'h2) begin
            sub_q <= 2'h0;
            ph_q  <= CRA_PH_01;
          end
        end
        CRA_PH_01: begin
          ph_q <= CRA_PH_00;
        end
        default: begin
          ph_q <= CRA_PH_00;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Character register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || clear_i) begin
      char_input_reg_q <= '0;
      par_q            <= 1'b0;
    end else if (st_pop) begin
      char_input_reg_q <= st_data.data;
      par_q            <= st_data.par_err;
    end else if (run && ph_q == CRA_PH_00) begin
      // Padding feeds zero characters; otherwise the register waits empty.
      char_input_reg_q <= '0;
      par_q            <= 1'b0;
    end
  end

  // Zero padding after a stop code from an input device in block mode.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || clear_i || start_i) begin
      pad_q <= 1'b0;
    end else if (st_pop && st_data.stop && !tape_device_level_i &&
                 word_or_block_select_i && !sign_interp_flag_i) begin
      pad_q <= 1'b1;
    end else if (run && ph_q == CRA_PH_01 && pos_q == `CRA_POS_LAST) begin
      pad_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Character position counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || clear_i || start_i) begin
      pos_q <= `CRA_POS_ZERO;
    end else if (run) begin
      // The preset waits for the pending store; presetting early would lift
      // the position off zero and let phase 10 slip past the busy stall.
      if (ph_q == CRA_PH_10 && pos_q == `CRA_POS_ZERO && !sign_interp_flag_i &&
          !end_mark && !bb_q) begin
        pos_q <= `CRA_POS_ONE;
      end else if (ph_q == CRA_PH_11 && sub_q == 2'h1) begin
        pos_q <= pos_d;
      end else if (ph_q == CRA_PH_01 && pos_q == `CRA_POS_LAST) begin
        pos_q <= `CRA_POS_ZERO;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Word assembly buffer
  // ---------------------------------------------------------------------------
  // The stored word is taken straight from the buffer at acknowledge, so the
  // buffer is emptied on that edge; phase 10 holds shifting until then only at position zero.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || clear_i || start_i) begin
      word_assembly_buffer_q <= '0;
    end else if (mem_ack_i && bb_q) begin
      word_assembly_buffer_q <= '0;
    end else if (run && ph_q == CRA_PH_11 && sub_q != 2'h1) begin
      word_assembly_buffer_q <= word_assembly_buffer_q << `CRA_SHIFT;
    end else if (run && ph_q == CRA_PH_01 && !end_mark) begin
      word_assembly_buffer_q[`CRA_SLICE_W-1:0] <=
        char_input_reg_q[`CRA_SLICE_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Busy bit, word/block counter and address counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || clear_i) begin
      bb_q <= 1'b0;
    end else if (run && ph_q == CRA_PH_11 && sub_q == 2'h1 && set_bb) begin
      bb_q <= 1'b1;
    end else if (mem_ack_i) begin
      bb_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wbc_q <= '0;
    end else if (start_i) begin
      wbc_q <= count_i;
    end else if (run && ph_q == CRA_PH_11 && sub_q == 2'h1 && dec_wbc && !wbc_zero) begin
      wbc_q <= wbc_q - WBC_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      adc_q <= '0;
    end else if (start_i) begin
      adc_q <= addr_i;
    end else if (mem_ack_i && bb_q) begin
      adc_q <= adc_q + `CRA_ADDR_W'(1);
    end
  end

  // ---------------------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || clear_i) begin
      fl_q <= '0;
    end else begin
      if (start_i) begin
        // Tape orders wait for a start mark; other devices have none.
        fl_q.block_mark_flag <= tape_device_level_i;
      end else if (st_pop && st_data.data == `CRA_START_MARK && fl_q.block_mark_flag) begin
        fl_q.block_mark_flag <= 1'b0;
      end else if (run && ph_q == CRA_PH_01 && pos_q == `CRA_POS_ZERO && end_mark) begin
        fl_q.block_mark_flag <= 1'b1;
      end
      if (run && ph_q == CRA_PH_10 && pos_q == `CRA_POS_ZERO && sign_interp_flag_i &&
          !legal_sign && !end_mark) begin
        fl_q.sign_error_flag <= 1'b1;
      end
      if (run && ph_q == CRA_PH_11 && sub_q == 2'h0 && par_q) begin
        fl_q.parity_error_flag <= 1'b1;
      end
      if (run && ph_q == CRA_PH_01 &&
          (start_mark || (end_mark && pos_q != `CRA_POS_ZERO))) begin
        fl_q.timing_read_error   <= 1'b1;
        fl_q.converter_halt_flag <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign mem_request_bit_o    = bb_q;
  assign mem_addr_o           = adc_q;
  assign mem_data_o           = word_assembly_buffer_q;
  assign end_level_o          = end_q;
  assign flags_o              = fl_q;
  assign phase_o              = {ph_q[1] | ph_q[2], ph_q[2] | ph_q[3]};
  assign char_pos_o           = pos_q;
  assign word_block_counter_o = wbc_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i || clear_i || start_i);

  sequence s_shift_pair;
    (ph_q == CRA_PH_11 && sub_q == 2'h0) ##1 (sub_q == 2'h1) ##1 (sub_q == 2'h2);
  endsequence

  a_phase_order: assert property (ph_q == CRA_PH_00 ##1 ph_q != CRA_PH_00 |->
                                  ph_q == CRA_PH_10)
    else $error("phase left 00 to a state other than 10");
  a_busy_stall: assert property (run && ph_q == CRA_PH_10 && bb_q && pos_q == '0 |=>
                                 ph_q == CRA_PH_10)
    else $error("phase 10 passed a pending store");
  a_shift_steps: assert property (run && ph_q == CRA_PH_11 && sub_q == 2'h0 &&
                                  !fl_q.converter_halt_flag && !mem_ack_i
                                  |-> s_shift_pair ##1 ph_q == CRA_PH_01)
    else $error("phase 11 did not take three steps");
  a_sign_check: assert property (run && ph_q == CRA_PH_10 && pos_q == '0 &&
                                 sign_interp_flag_i && !legal_sign && !end_mark
                                 |=> fl_q.sign_error_flag)
    else $error("illegal sign not flagged");
  a_pos_preset: assert property (run && ph_q == CRA_PH_10 && pos_q == '0 &&
                                 !sign_interp_flag_i && !end_mark && !bb_q
                                 |=> pos_q == `CRA_POS_ONE)
    else $error("position not preset to one");
  a_addr_step: assert property (mem_ack_i && bb_q |=> adc_q == $past(adc_q) + 15'h1 &&
                                !bb_q)
    else $error("store did not step the address");
  a_halt_freeze: assert property (fl_q.converter_halt_flag |=> $stable(ph_q) &&
                                  $stable(pos_q))
    else $error("converter moved while halted");
  a_bad_mark: assert property (run && ph_q == CRA_PH_01 && start_mark
                               |=> fl_q.timing_read_error && fl_q.converter_halt_flag
                               ##1 ph_q == CRA_PH_00)
    else $error("start mark in phase 01 not trapped");
  a_block_flag: assert property (run && ph_q == CRA_PH_01 && pos_q == '0 && end_mark
                                 |=> fl_q.block_mark_flag && ph_q == CRA_PH_00)
    else $error("end mark did not set block flag");
  a_pos_wrap: assert property (run && ph_q == CRA_PH_01 && pos_q == `CRA_POS_LAST
                               |=> pos_q == '0)
    else $error("position seven did not wrap");
endmodule

// [cra_char_src.sv]
// Character source standing in for the tape unit or input device.
// Assumes cra_pkg is compiled first; the bench queues characters with push().
`timescale 1ns/1ns
module cra_char_src (
  // Clock.
  input  wire logic          clk_i,
  // Handshake towards the converter.
  input  wire logic          ready_i,
  output logic               valid_o,
  output cra_pkg::cra_char_t char_o
);
  import cra_pkg::*;

  cra_char_t q[$];

  // Queues one character for delivery.
  task automatic push(input cra_char_t c);
    q.push_back(c);
  endtask

  // An offer is taken at the rising edge where ready is high.
  always @(posedge clk_i) begin
    if (valid_o && ready_i && q.size() > 0) begin
      void'(q.pop_front());
    end
  end

  // Offers change at the falling edge only. An idle line inverts its data at every
  // falling edge, so a stale character cannot pass for a fresh one.
  always @(negedge clk_i) begin
    if (q.size() > 0) begin
      valid_o <= 1'h1;
      char_o  <= q[0];
    end else begin
      valid_o <= 1'h0;
      char_o  <= ~char_o;
    end
  end

  // Quiet line before the first character.
  initial begin
    valid_o = 1'h0;
    char_o  = '0;
  end
endmodule

// [cra_read_asm_tb.sv]
// Self-checking bench for the read-direction word assembler.
// Assumes cra_pkg, cra_read_asm and cra_char_src are compiled before it.
`timescale 1ns/1ns
`include "cra_regs.svh"
module cra_read_asm_tb;
  import cra_pkg::*;
  typedef struct {logic tp; logic sg; logic [7:0] s0; logic [14:0] adr; logic se;} cra_row_t;
  logic        clk_i, rst_b_i, clear_i, start_i, sign_i, tape_i, ack_i, valid, ready, busy, done;
  logic        wb;
  logic [11:0] count_i, word_block_counter;
  logic [14:0] addr_i, maddr;
  logic [36:0] mdata, w;
  logic [36:0] ws[3];
  logic [4:0]  snap;
  logic [1:0]  ph, last_ph;
  logic [2:0]  pos;
  cra_char_t   ch;
  cra_flags_t  fl;
  cra_row_t    rows[4];
  int          n;
  int          num_errors = 0;
  int          samples_checked = 0;

  cra_read_asm u_cra_read_asm (.clk_i(clk_i), .rst_b_i(rst_b_i), .clear_i(clear_i),
    .start_i(start_i), .word_or_block_select_i(wb), .sign_interp_flag_i(sign_i),
    .tape_device_level_i(tape_i), .count_i(count_i), .addr_i(addr_i), .char_valid_i(valid),
    .char_ready_o(ready), .char_i(ch), .mem_request_bit_o(busy), .mem_ack_i(ack_i),
    .mem_addr_o(maddr), .mem_data_o(mdata), .end_level_o(done), .flags_o(fl),
    .phase_o(ph), .char_pos_o(pos), .word_block_counter_o(word_block_counter));
  cra_char_src u_cra_char_src (.clk_i(clk_i), .ready_i(ready), .valid_o(valid), .char_o(ch));

  // Free-running 20 MHz clock.
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end

  // Value compare; x counts as a match only against x, and z only against z, in the same expected bit.
  task automatic chk(input logic [36:0] g, input logic [36:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic finish_test;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hang would otherwise stall the run forever; the tests need well under this.
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    finish_test;
  end

  // Every phase change flips one bit of ph along 00, 10, 11, 01.
  always @(posedge clk_i) begin
    if (!rst_b_i || clear_i) begin
      last_ph <= 2'h0;
    end else if (ph !== last_ph) begin
      chk(ph, {~last_ph[0], last_ph[1]});
      last_ph <= ph;
    end
  end

  task automatic do_clear;
    @(negedge clk_i);
    clear_i = 1'h1;
    @(negedge clk_i);
    clear_i = 1'h0;
  endtask

  task automatic do_start(input logic tp, sg, input logic [11:0] c, input logic [14:0] a);
    tape_i = tp;
    sign_i = sg;
    count_i = c;
    addr_i = a;
    start_i = 1'h1;
    @(negedge clk_i);
    start_i = 1'h0;
  endtask

  // Queues one word of characters and works out the word it should assemble.
  task automatic send(input logic sg, input logic [7:0] s0, input int pk, output logic [36:0] v);
    cra_char_t c;
    v = '0;
    for (int k = 0; k < (sg ? 7 : 6); k++) begin
      c = '{1'h0, k == pk, (sg && k == 0) ? s0 : 8'h11 + k[7:0]};
      u_cra_char_src.push(c);
      v = {v[30:0], c.data[5:0]};
    end
  endtask

  // Memory side: waits for the busy bit, stalls, checks the word, acknowledges.
  task automatic serve(input logic [36:0] ew, input logic [14:0] ea, input int d, input logic st);
    n = 0;
    while (busy !== 1'h1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    repeat (d) @(negedge clk_i);
    if (st) begin
      chk(ph, 2'h2);
    end
    chk(mdata, ew);
    chk(maddr, ea);
    ack_i = 1'h1;
    @(negedge clk_i);
    ack_i = 1'h0;
    chk(busy, 1'h0);
  endtask

  task automatic wait_end;
    n = 0;
    while (done !== 1'h1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    chk(done, 1'h1);
  endtask

  initial begin
    {rst_b_i, clear_i, start_i, sign_i, tape_i, ack_i, wb} = 7'h0;
    count_i = 12'h0;
    addr_i = 15'h0;
    rows[0] = '{1'h1, 1'h0, 8'h00, 15'h0100, 1'h0};
    rows[1] = '{1'h1, 1'h1, 8'h01, 15'h0200, 1'h0};
    rows[2] = '{1'h0, 1'h1, 8'h02, 15'h0300, 1'h0};
    rows[3] = '{1'h0, 1'h1, 8'h05, 15'h0400, 1'h1};
    repeat (16) @(negedge clk_i);
    rst_b_i = 1'h1;
    @(negedge clk_i);
    chk({busy, done, fl, ph, pos}, 37'h0);
    chk({maddr, word_block_counter, ready}, 37'h1);
    // One single-word order per row, tape and input device.
    foreach (rows[i]) begin
      do_clear;
      do_start(rows[i].tp, rows[i].sg, 12'h001, rows[i].adr);
      if (rows[i].tp) begin
        // An empty block first: its end mark raises the block flag until the next start mark.
        u_cra_char_src.push('{1'h0, 1'h0, `CRA_START_MARK});
        u_cra_char_src.push('{1'h0, 1'h0, `CRA_END_MARK});
        u_cra_char_src.push('{1'h0, 1'h0, `CRA_START_MARK});
      end
      send(rows[i].sg, rows[i].s0, -1, w);
      serve(w, rows[i].adr, 4, 1'h0);
      wait_end;
      chk({word_block_counter, maddr}, {12'h0, rows[i].adr + 15'h1});
      chk(fl.sign_error_flag, rows[i].se);
      chk({fl.block_mark_flag, fl.timing_read_error}, 2'h0);
    end
    // Fill the buffer while idle, then drain it against a slow memory.
    do_clear;
    for (int j = 0; j < 3; j++) begin
      send(1'h1, (j == 1) ? 8'h02 : 8'h01, (j == 1) ? 3 : -1, ws[j]);
    end
    repeat (30) @(negedge clk_i);
    chk(ready, 1'h0);
    do_start(1'h0, 1'h1, 12'h003, 15'h7FFE);
    serve(ws[0], 15'h7FFE, 30, 1'h1);
    serve(ws[1], 15'h7FFF, 30, 1'h1);
    serve(ws[2], 15'h0000, 4, 1'h0);
    wait_end;
    chk({fl.parity_error_flag, fl.sign_error_flag, maddr, ready}, 37'h20003);
    // A stop code in block mode pads the word out with zero characters.
    do_clear;
    wb = 1'h1;
    do_start(1'h0, 1'h0, 12'h001, 15'h0020);
    u_cra_char_src.push('{1'h0, 1'h0, 8'h15});
    u_cra_char_src.push('{1'h1, 1'h0, 8'h2A});
    serve({1'h0, 6'h15, 6'h2A, 24'h0}, 15'h0020, 4, 1'h0);
    wait_end;
    chk(word_block_counter, 37'h0);
    wb = 1'h0;
    // A second start mark in mid-word is a timing error that halts.
    do_clear;
    do_start(1'h1, 1'h0, 12'h001, 15'h0010);
    u_cra_char_src.push('{1'h0, 1'h0, `CRA_START_MARK});
    u_cra_char_src.push('{1'h0, 1'h0, 8'h11});
    u_cra_char_src.push('{1'h0, 1'h0, `CRA_START_MARK});
    u_cra_char_src.push('{1'h0, 1'h0, 8'h12});
    n = 0;
    while (fl.converter_halt_flag !== 1'h1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    chk({fl.timing_read_error, fl.converter_halt_flag}, 2'h3);
    snap = {ph, pos};
    repeat (20) @(negedge clk_i);
    chk({ph, pos}, snap);
    do_clear;
    chk({busy, fl, ph, pos}, 37'h0);
    finish_test;
  end
endmodule
